//--- design/sram_pin_pkg.sv
package sram_pin_pkg;
  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BURST_W = 2;
  // ****************************************************************
  // encodings and reset values
  // ****************************************************************
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic [31:0] DATA_ZERO = 32'h0;
  localparam logic [3:0] PAR_ZERO = 4'h0;
  localparam logic [3:0] LANES_ALL = 4'hf;
  localparam logic [3:0] LANES_NONE = 4'h0;
  // sleep entry and exit count this many clock cycles, then change phase on the next edge
  localparam int SLEEP_CYCLES = 2;
  localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
  localparam logic [1:0] SLEEP_CNT_FULL = 2'(SLEEP_CYCLES);

  // access phase of the pin controller
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WPEND = 2'b11,
    ST_SLEEP = 2'b10
  } phase_t;
endpackage : sram_pin_pkg

//--- design/burst_step.sv
`timescale 1ns/10ps
// ******************************************************************
// next burst address for linear or interleaved order
// ******************************************************************
module burst_step
  import sram_pin_pkg::*;
(
  // burst position
  input wire logic [BURST_W-1:0] start_i,
  input wire logic [BURST_W-1:0] count_i,
  input wire logic interleave_i,
  // resulting low address bits
  output logic [BURST_W-1:0] addr_o
);
  wire [BURST_W-1:0] lin_addr;
  wire [BURST_W-1:0] ilv_addr;
  // linear adds the step count, interleaved xors it in
  assign lin_addr = BURST_W'(start_i + count_i);
  assign ilv_addr = start_i ^ count_i;
  assign addr_o = interleave_i ? ilv_addr : lin_addr;
endmodule : burst_step

//--- design/sync_burst_sram_pin_control.sv
`timescale 1ns/10ps
module sync_burst_sram_pin_control
  import sram_pin_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // address and strobes
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  // selects
  input wire logic select_low_a_i,
  input wire logic select_high_i,
  input wire logic select_low_b_i,
  // write controls
  input wire logic whole_word_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic [LANES-1:0] byte_lane_select_n_i,
  // asynchronous controls
  input wire logic output_drive_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_interleave_i,
  // data pins, split into in, out and enable
  input wire logic [DATA_W-1:0] data_in_i,
  output logic [DATA_W-1:0] data_out_o,
  output logic [DATA_W-1:0] data_oe_o,
  input wire logic [LANES-1:0] parity_io_in_i,
  output logic [LANES-1:0] parity_io_out_o,
  output logic [LANES-1:0] parity_io_oe_o,
  // status
  output logic sleeping_o
);
  // ****************************************************************
  // storage and state
  // ****************************************************************
  // each lane keeps its own array so one process writes each store
  wire [DATA_W-1:0] rd_word;
  wire [LANES-1:0] rd_pbit;
  phase_t phase;
  phase_t next_phase;
  logic [ADDR_W-1:0] base_addr;
  logic [BURST_W-1:0] burst_cnt;
  logic [DATA_W-1:0] data_reg;
  logic [LANES-1:0] par_reg;
  logic [DATA_W-1:0] rd_data;
  logic [LANES-1:0] rd_par;
  logic [1:0] sleep_cnt;

  // ****************************************************************
  // input decode
  // ****************************************************************
  wire selected;
  wire processor_addr_strobe_n_take;
  wire controller_addr_strobe_n_take;
  wire strobe_take;
  wire write_req;
  wire [LANES-1:0] lane_wr;
  wire awake;
  wire [BURST_W-1:0] cur_low;
  wire [ADDR_W-1:0] cur_addr;
  wire [ADDR_W-1:0] wr_addr;
  wire [ADDR_W-1:0] rd_addr;
  wire writing;

  // an open sleep pin is modelled by the bench as low
  assign awake = (phase != ST_SLEEP) && !sleep_request_i;
  assign selected = !select_low_a_i && select_high_i
    && !select_low_b_i;
  // the first select vetoes the processor strobe, and so do the other two selects through selected
  assign processor_addr_strobe_n_take = awake && !processor_addr_strobe_n_i
    && !select_low_a_i && selected;
  // controller strobe only counts when processor strobe is idle
  assign controller_addr_strobe_n_take = awake && !controller_addr_strobe_n_i
    && processor_addr_strobe_n_i && selected;
  assign strobe_take = processor_addr_strobe_n_take || controller_addr_strobe_n_take;
  // whole-word write overrides the byte controls
  assign lane_wr = !whole_word_write_n_i ? LANES_ALL :
    (!byte_write_enable_n_i ? ~byte_lane_select_n_i
      : LANES_NONE);
  assign write_req = |lane_wr;
  // burst address from base and counter
  burst_step u_step (
    .start_i(base_addr[BURST_W-1:0]),
    .count_i(burst_cnt),
    .interleave_i(burst_interleave_i),
    .addr_o(cur_low)
  );
  assign cur_addr = {base_addr[ADDR_W-1:BURST_W], cur_low};
  // an CONTROLLER_ADDR_STROBE_N write uses the fresh address at once
  assign wr_addr = controller_addr_strobe_n_take ? addr_i : cur_addr;
  // a fresh strobe reads the new address, else the burst address
  assign rd_addr = strobe_take ? addr_i : cur_addr;
  // write inputs are ignored on the PROCESSOR_ADDR_STROBE_N first cycle
  assign writing = awake && write_req && !processor_addr_strobe_n_take
    && (controller_addr_strobe_n_take || phase == ST_WPEND || phase == ST_READ);

  // ****************************************************************
  // phase machine
  // ****************************************************************
  // sleep is entered and left over a fixed cycle count
  always_comb begin
    next_phase = phase;
    case (phase)
      ST_IDLE, ST_READ, ST_WPEND: begin
        if (sleep_request_i && sleep_cnt == SLEEP_CNT_FULL) begin
          next_phase = ST_SLEEP;
        end else if (processor_addr_strobe_n_take) begin
          next_phase = ST_WPEND;
        end else if (controller_addr_strobe_n_take) begin
          next_phase = write_req ? ST_IDLE : ST_READ;
        end else if (writing) begin
          next_phase = ST_WPEND;
        end else if (phase == ST_WPEND) begin
          next_phase = ST_READ;
        end
      end
      ST_SLEEP: begin
        if (!sleep_request_i && sleep_cnt == SLEEP_CNT_FULL) begin
          next_phase = ST_IDLE;
        end
      end
      default: next_phase = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      phase <= ST_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // count cycles while the sleep pin disagrees with the phase
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sleep_cnt <= SLEEP_CNT_ZERO;
    end else if (sleep_request_i != (phase == ST_SLEEP)
                 && sleep_cnt != SLEEP_CNT_FULL) begin
      sleep_cnt <= 2'(sleep_cnt + 2'h1);
    end else begin
      sleep_cnt <= SLEEP_CNT_ZERO;
    end
  end

  // ****************************************************************
  // address and burst counter
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      base_addr <= '0;
      burst_cnt <= BURST_ZERO;
    end else if (strobe_take) begin
      base_addr <= addr_i;
      burst_cnt <= BURST_ZERO;
    end else if (awake && !burst_advance_n_i) begin
      burst_cnt <= 2'(burst_cnt + BURST_STEP);
    end
  end

  // ****************************************************************
  // data capture and array
  // ****************************************************************
  // input register samples pins every edge while awake
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      data_reg <= DATA_ZERO;
      par_reg <= PAR_ZERO;
    end else if (awake) begin
      data_reg <= data_in_i;
      par_reg <= parity_io_in_i;
    end
  end

  // one lane of data and parity per select bit
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [DEPTH];
      logic lane_par [DEPTH];
      always_ff @(posedge mclk_i) begin
        if (writing && lane_wr[g]) begin
          lane_mem[wr_addr] <= data_in_i[g*LANE_W +: LANE_W];
          lane_par[wr_addr] <= parity_io_in_i[g];
        end
      end
      assign rd_word[g*LANE_W +: LANE_W] = lane_mem[rd_addr];
      assign rd_pbit[g] = lane_par[rd_addr];
    end
  endgenerate

  // read data registered from the address set last edge
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rd_data <= DATA_ZERO;
      rd_par <= PAR_ZERO;
    end else if (awake) begin
      rd_data <= rd_word;
      rd_par <= rd_pbit;
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  wire drive;
  // output drive is asynchronous; writes always float the bus
  // the cycle after a processor strobe already shows read data
  assign drive = !output_drive_n_i
    && (phase == ST_READ || phase == ST_WPEND)
    && !writing;
  assign data_out_o = rd_data;
  assign parity_io_out_o = rd_par;
  assign data_oe_o = {DATA_W{drive}};
  assign parity_io_oe_o = {LANES{drive}};
  assign sleeping_o = (phase == ST_SLEEP);
endmodule : sync_burst_sram_pin_control

//--- verif/sram_pin_props.sv
`timescale 1ns/10ps
// ************
// pin checker
// ************
module sram_pin_props
  import sram_pin_pkg::*;
(
  // clock, reset and host pins
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic select_low_a_i,
  input wire logic select_high_i,
  input wire logic select_low_b_i,
  input wire logic whole_word_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic output_drive_n_i,
  input wire logic sleep_request_i,
  // memory outputs
  input wire logic [DATA_W-1:0] data_oe_o,
  input wire logic [LANES-1:0] parity_io_oe_o,
  input wire logic sleeping_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // selection, write inputs idle, and pin drive summaries
  wire sel = !select_low_a_i && select_high_i && !select_low_b_i;
  wire nowr = whole_word_write_n_i && byte_write_enable_n_i;
  wire drv_off = data_oe_o == '0 && parity_io_oe_o == '0;
  wire drv_on = &{data_oe_o, parity_io_oe_o};
  property p_drive_off; output_drive_n_i |-> drv_off; endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive off");
  property p_write_hiz;
    sel && !controller_addr_strobe_n_i && processor_addr_strobe_n_i
      && !whole_word_write_n_i |=> drv_off;
  endproperty
  a_write_hiz: assert property (p_write_hiz) else $error("write drove");
  property p_read;
    sel && !processor_addr_strobe_n_i && !sleep_request_i && !sleeping_o
      |=> !output_drive_n_i && nowr |-> drv_on;
  endproperty
  a_read: assert property (p_read) else $error("read undriven");
  property p_gate;
    select_low_a_i && !processor_addr_strobe_n_i && controller_addr_strobe_n_i
      && !output_drive_n_i && nowr && drv_off |=> drv_off;
  endproperty
  a_gate: assert property (p_gate) else $error("gated strobe taken");
  property p_sleep_in; sleep_request_i [*4] |-> sleeping_o; endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("no sleep");
  property p_wake; !sleep_request_i [*4] |-> !sleeping_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  // entry only after the pin stood high for two samples
  property p_steady;
    $rose(sleeping_o)
      |-> $past(sleep_request_i) && $past(sleep_request_i, 2);
  endproperty
  a_steady: assert property (p_steady) else $error("early sleep");
  property p_quiet; sleeping_o |-> drv_off; endproperty
  a_quiet: assert property (p_quiet) else $error("drives asleep");
  c_read: cover property (drv_on);
  c_sleep: cover property (sleeping_o);
  c_both: cover property (!processor_addr_strobe_n_i
    && !controller_addr_strobe_n_i);
endmodule : sram_pin_props

//--- verif/cache_host_model.sv
`timescale 1ns/10ps
// ************
// host model
// ************
module cache_host_model
  import sram_pin_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // pins into the memory, named as the memory sees them
  output logic [ADDR_W-1:0] addr_i,
  output logic processor_addr_strobe_n_i, controller_addr_strobe_n_i,
  output logic burst_advance_n_i, whole_word_write_n_i, byte_write_enable_n_i,
  output logic select_low_a_i, select_high_i, select_low_b_i,
  output logic output_drive_n_i, sleep_request_i, burst_interleave_i,
  output logic [LANES-1:0] byte_lane_select_n_i, host_dp_o,
  output logic [DATA_W-1:0] host_dq_o
);
  // inactive pins; a bus released after a write shows the inverse of its last value
  task automatic idle(logic [35:0] rel);
    {processor_addr_strobe_n_i, controller_addr_strobe_n_i} <= 2'h3;
    {select_low_a_i, select_high_i, select_low_b_i} <= 3'h2;
    {whole_word_write_n_i, byte_write_enable_n_i} <= 2'h3;
    byte_lane_select_n_i <= LANES_ALL;
    {host_dp_o, host_dq_o} <= rel;
  endtask : idle
  // unconnected sleep reads low, unconnected order reads interleaved
  initial begin
    {addr_i, burst_advance_n_i, output_drive_n_i} = {17'h0, 2'h3};
    {sleep_request_i, burst_interleave_i} = 2'h1;
    idle(36'h0);
  end
  // controller-strobe write; bus released one cycle before data appears
  task automatic wr(logic [16:0] a, logic [35:0] d, logic gw, logic [3:0] bw);
    @(posedge mclk_i);
    {output_drive_n_i, burst_advance_n_i} <= 2'h3;
    @(posedge mclk_i);
    {addr_i, controller_addr_strobe_n_i} <= {a, 1'b0};
    {whole_word_write_n_i, byte_write_enable_n_i} <= {gw, 1'b0};
    byte_lane_select_n_i <= bw;
    {host_dp_o, host_dq_o} <= d;
    @(posedge mclk_i);
    idle(~d);
  endtask : wr
  // processor-strobe read; both strobes plus write inputs when asked
  task automatic rd(logic [16:0] a, logic m, logic both, logic gate);
    @(posedge mclk_i);
    {addr_i, burst_interleave_i, output_drive_n_i} <= {a, m, 1'b0};
    {processor_addr_strobe_n_i, select_low_a_i} <= {1'b0, gate};
    {controller_addr_strobe_n_i, whole_word_write_n_i} <= {2{!both}};
    @(posedge mclk_i);
    idle({host_dp_o, host_dq_o});
    burst_advance_n_i <= 1'b0;
  endtask : rd
endmodule : cache_host_model

//--- verif/tb.sv
`timescale 1ns/10ps
// ************
// bench
// ************
module tb;
  import sram_pin_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] addr_i, base;
  logic processor_addr_strobe_n_i, controller_addr_strobe_n_i, sleeping_o;
  logic burst_advance_n_i, select_low_a_i, select_high_i, select_low_b_i;
  logic whole_word_write_n_i, byte_write_enable_n_i, output_drive_n_i;
  logic sleep_request_i, burst_interleave_i;
  logic [LANES-1:0] byte_lane_select_n_i, parity_io_in_i, host_dp_o;
  logic [LANES-1:0] parity_io_out_o, parity_io_oe_o;
  logic [DATA_W-1:0] data_in_i, data_out_o, data_oe_o, host_dq_o;
  logic [35:0] ref_mem [logic [ADDR_W-1:0]];
  int seed = 68234;
  int num_errors = 0;
  int checks_done = 0;
  always #20 mclk_i = ~mclk_i;
  // shared pins: whoever enables drives, the other side reads
  assign data_in_i = (data_oe_o & data_out_o) | (~data_oe_o & host_dq_o);
  assign parity_io_in_i = (parity_io_oe_o & parity_io_out_o)
      | (~parity_io_oe_o & host_dp_o);
  cache_host_model host (.*);
  sync_burst_sram_pin_control dut (.*);
  // expected low address bits at burst step i
  function automatic logic [1:0] nxt(logic [1:0] s, int i, logic m);
    return m ? s ^ 2'(i) : s + 2'(i);
  endfunction : nxt
  // lanes replaced by one write, parity bit with its lane
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] d,
      logic gw, logic [3:0] bw);
    for (int g = 0; g < LANES; g++) begin
      if (!gw || !bw[g]) begin
        o[8*g +: 8] = d[8*g +: 8];
        o[32+g] = d[32+g];
      end
    end
    return o;
  endfunction : merge
  task automatic check(logic [35:0] got, logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic wr_ref(logic [16:0] a, logic [35:0] d, logic gw, logic [3:0] bw);
    host.wr(a, d, gw, bw);
    ref_mem[a] = merge(ref_mem[a], d, gw, bw);
  endtask : wr_ref
  // four-beat burst; advance held low for three edges
  task automatic burst(logic [16:0] a, logic m, logic both);
    host.rd(a, m, both, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      if (i == 2) host.burst_advance_n_i <= 1'b1;
      #1;
      check({parity_io_out_o, data_out_o}, ref_mem[{a[16:2], nxt(a[1:0], i, m)}]);
      check({parity_io_oe_o, data_oe_o}, '1);
    end
  endtask : burst
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      base = 17'($random(seed)) & ~17'h3;
      for (int j = 0; j < 4; j++) begin
        wr_ref(base | 17'(j), 36'({$random(seed), $random(seed)}), 1'b0, 4'(n));
      end
      wr_ref(base | 17'(n & 3), 36'($random(seed)), 1'b1, 4'($random(seed)));
      burst(base | 17'($random(seed) & 3), n[0], n[1]);
    end
    wr_ref(base, 36'($random(seed)), 1'b0, LANES_ALL);
    host.rd(base, 1'b0, 1'b0, 1'b1);
    @(posedge mclk_i);
    #1;
    check({parity_io_oe_o, data_oe_o}, 36'h0);
    @(posedge mclk_i);
    host.sleep_request_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    check(36'(sleeping_o), 36'h1);
    host.wr(base, ~ref_mem[base], 1'b0, LANES_ALL);
    host.sleep_request_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    check(36'(sleeping_o), 36'h0);
    burst(base, 1'b1, 1'b0);
    give_verdict;
  end
  // about two hundred cycles expected; this cuts a hang short
  initial begin
    repeat (4000) @(posedge mclk_i);
    num_errors++;
    give_verdict;
  end
endmodule : tb
bind sync_burst_sram_pin_control sram_pin_props chk (.*);
